// File: hdl/smir_params.svh
// smir_params.svh: offsets, field layouts, reset values and submessage codes
// for the submessage info receiver; definitions only
`ifndef SMIR_PARAMS_SVH
`define SMIR_PARAMS_SVH

// submessage kinds
`define SMIR_KIND_PAD 8'h01
`define SMIR_KIND_FRAG_NACK 8'h12
`define SMIR_KIND_SRC_INFO 8'h0c
`define SMIR_KIND_TIME_INFO 8'h09
`define SMIR_KIND_DATA 8'h15
`define SMIR_KIND_FRAG_DATA 8'h16
// header flag bits
`define SMIR_FLAG_BYTE_ORDER 0
`define SMIR_FLAG_TS_ABSENT 1
// least body lengths in bytes
`define SMIR_LEN_SRC_INFO 16'h0014
`define SMIR_LEN_TIME_INFO 16'h0008
`define SMIR_LEN_FRAG_NACK 16'h0020
// body byte offsets of fields
`define SMIR_OFS_SRC_VER 16'h0004
`define SMIR_OFS_SRC_VENDOR 16'h0006
`define SMIR_OFS_SRC_PREFIX 16'h0008
`define SMIR_OFS_NK_READER 16'h0000
`define SMIR_OFS_NK_WRITER 16'h0004
`define SMIR_OFS_NK_SEQ 16'h0008
`define SMIR_OFS_NK_BASE 16'h0010
`define SMIR_OFS_NK_NBITS 16'h0014
`define SMIR_OFS_NK_BITMAP 16'h0018
`define SMIR_OFS_NK_COUNT 16'h001c
`define SMIR_NBITS_MAX 32'h00000100
`define SMIR_NULL_LOCATOR 8'h00
`define SMIR_ZERO_PREFIX 96'h0

// apb register byte addresses
`define SMIR_ADDR_STATUS 12'h000
`define SMIR_ADDR_IRQ_STAT 12'h004
`define SMIR_ADDR_IRQ_MASK 12'h008
`define SMIR_ADDR_CTRL 12'h00c
`define SMIR_ADDR_TS_LO 12'h010
`define SMIR_ADDR_TS_HI 12'h014
`define SMIR_ADDR_PREFIX0 12'h018
`define SMIR_ADDR_PREFIX1 12'h01c
`define SMIR_ADDR_PREFIX2 12'h020
`define SMIR_ADDR_VER_VENDOR 12'h024
`define SMIR_ADDR_NK_SEQ 12'h028
`define SMIR_ADDR_NK_BITMAP 12'h02c
`define SMIR_ADDR_NK_BASE 12'h030
`define SMIR_ADDR_NK_COUNT 12'h034
`define SMIR_ADDR_NK_WRITER 12'h038
`define SMIR_ADDR_NK_READER 12'h03c
// interrupt status bit positions
`define SMIR_IRQ_SRC 0
`define SMIR_IRQ_TIME 1
`define SMIR_IRQ_NACK 2
`define SMIR_IRQ_INVALID 3
`define SMIR_IRQ_W 4
`endif

// File: hdl/smir_pkg.sv
// smir_pkg: types shared by the submessage info receiver files
`include "smir_params.svh"
package smir_pkg;
   typedef enum logic [1:0] {smir_idle, smir_body, smir_done} smir_state_t;

   typedef struct packed {
      smir_state_t st;
      logic [7:0] kind;
      logic [7:0] flags;
      logic [15:0] len;
      logic [15:0] pos;
      logic [63:0] ts_raw;
      logic [95:0] src_prefix;
      logic [15:0] src_ver;
      logic [15:0] src_vendor;
      logic [31:0] nk_reader;
      logic [31:0] nk_writer;
      logic [63:0] nk_seq;
      logic [31:0] nk_base;
      logic [31:0] nk_nbits;
      logic [31:0] nk_bitmap;
      logic [31:0] nk_count;
   } smir_parse_t;

   typedef struct packed {
      logic [95:0] source_prefix;
      logic [15:0] src_ver;
      logic [15:0] src_vendor;
      logic [7:0] ucast_reply;
      logic [7:0] mcast_reply;
      logic timestamp_valid;
      logic [63:0] timestamp;
      logic [95:0] wr_prefix;
      logic [31:0] wr_entity;
      logic [95:0] rd_prefix;
      logic [31:0] rd_entity;
      logic [63:0] nk_seq;
      logic [31:0] nk_base;
      logic [31:0] nk_nbits;
      logic [31:0] nk_bitmap;
      logic [31:0] nk_count;
      logic nk_valid;
      logic [`SMIR_IRQ_W-1:0] irq_stat;
      logic [`SMIR_IRQ_W-1:0] irq_mask;
      logic skew_detected;
      logic [31:0] prdata;
   } smir_ctx_t;
endpackage

// File: hdl/smir_parser.sv
// smir_parser: walks one submessage body byte by byte and gathers fields
// assumes bytes arrive in order after the header strobe, one per enabled cycle
`timescale 1ns/1ns
`include "smir_params.svh"
module smir_parser import smir_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic hdr_valid,
   input wire logic [7:0] hdr_kind,
   input wire logic [7:0] hdr_flags,
   input wire logic [15:0] hdr_len,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   output logic done,
   output smir_parse_t fields
);
   smir_parse_t q, d;

   // place one byte into a word honouring the submessage byte order
   function automatic logic [63:0] put_byte(input logic [63:0] w, input logic [15:0] idx, input logic [7:0] b,
                                            input logic le, input logic [3:0] nbytes);
      logic [63:0] r;
      logic [3:0] sh;
      r = w;
      sh = le ? idx[3:0] : 4'(nbytes - 4'h1 - idx[3:0]);
      r[{sh[2:0], 3'h0} +: 8] = b;
      return r;
   endfunction

   always_comb begin
      logic le;
      logic [15:0] p;
      d = q;
      le = q.flags[`SMIR_FLAG_BYTE_ORDER];
      p = q.pos;
      case (q.st)
         smir_idle: begin
            if (hdr_valid) begin
               d = '0;
               d.kind = hdr_kind;
               d.flags = hdr_flags;
               d.len = hdr_len;
               d.st = (hdr_len == 16'h0) ? smir_done : smir_body;
            end
         end
         smir_body: begin
            if (byte_valid) begin
               d.pos = 16'(p + 16'h1);
               if (q.kind == `SMIR_KIND_TIME_INFO && !q.flags[`SMIR_FLAG_TS_ABSENT] && p < `SMIR_LEN_TIME_INFO) begin
                  d.ts_raw = put_byte(q.ts_raw, p, byte_data, le, 4'h8);
               end else if (q.kind == `SMIR_KIND_SRC_INFO) begin
                  if (p >= `SMIR_OFS_SRC_VER && p < `SMIR_OFS_SRC_VENDOR)
                     d.src_ver = 16'(put_byte(64'(q.src_ver), 16'(p - `SMIR_OFS_SRC_VER), byte_data, 1'b0, 4'h2));
                  else if (p >= `SMIR_OFS_SRC_VENDOR && p < `SMIR_OFS_SRC_PREFIX)
                     d.src_vendor = 16'(put_byte(64'(q.src_vendor), 16'(p - `SMIR_OFS_SRC_VENDOR), byte_data, 1'b0, 4'h2));
                  else if (p >= `SMIR_OFS_SRC_PREFIX && p < `SMIR_LEN_SRC_INFO)
                     d.src_prefix = {q.src_prefix[87:0], byte_data};
               end else if (q.kind == `SMIR_KIND_FRAG_NACK) begin
                  if (p < `SMIR_OFS_NK_WRITER)
                     d.nk_reader = {q.nk_reader[23:0], byte_data};
                  else if (p < `SMIR_OFS_NK_SEQ)
                     d.nk_writer = {q.nk_writer[23:0], byte_data};
                  else if (p < `SMIR_OFS_NK_BASE)
                     d.nk_seq = put_byte(q.nk_seq, 16'(p - `SMIR_OFS_NK_SEQ), byte_data, le, 4'h8);
                  else if (p < `SMIR_OFS_NK_NBITS)
                     d.nk_base = 32'(put_byte(64'(q.nk_base), 16'(p - `SMIR_OFS_NK_BASE), byte_data, le, 4'h4));
                  else if (p < `SMIR_OFS_NK_BITMAP)
                     d.nk_nbits = 32'(put_byte(64'(q.nk_nbits), 16'(p - `SMIR_OFS_NK_NBITS), byte_data, le, 4'h4));
                  else if (p < `SMIR_OFS_NK_COUNT)
                     d.nk_bitmap = 32'(put_byte(64'(q.nk_bitmap), 16'(p - `SMIR_OFS_NK_BITMAP), byte_data, le, 4'h4));
                  else if (p < `SMIR_LEN_FRAG_NACK)
                     d.nk_count = 32'(put_byte(64'(q.nk_count), 16'(p - `SMIR_OFS_NK_COUNT), byte_data, le, 4'h4));
               end
               // pad and unknown bodies are only counted off
               if (16'(p + 16'h1) == q.len)
                  d.st = smir_done;
            end
         end
         default: d.st = smir_idle;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         q <= '0;
      else
         q <= d;
   end

   assign done = (q.st == smir_done);
   assign fields = q;
endmodule // smir_parser

// File: hdl/smir_receiver.sv
// smir_receiver: receiver context for source, time, fragment-nack and pad submessages, with apb registers
// assumes the message stream is synchronous to pclk and a header is offered only when hdr_ready is high
`timescale 1ns/1ns
`include "smir_params.svh"
module smir_receiver import smir_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic msg_start,
   input wire logic [95:0] dest_prefix,
   input wire logic [63:0] reception_time,
   input wire logic [63:0] send_timestamp,
   input wire logic hdr_valid,
   output logic hdr_ready,
   input wire logic [7:0] hdr_kind,
   input wire logic [7:0] hdr_flags,
   input wire logic [15:0] hdr_len,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   output logic data_ts_valid,
   output logic [63:0] data_ts,
   output logic [7:0] ucast_reply,
   output logic [7:0] mcast_reply,
   output logic nack_valid,
   output logic [127:0] nack_writer_guid,
   output logic [127:0] nack_reader_guid,
   output logic [63:0] nack_seq,
   output logic [31:0] nack_base,
   output logic [31:0] nack_nbits,
   output logic [31:0] nack_bitmap,
   output logic [31:0] nack_count,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq
);
   smir_ctx_t q, d;
   logic done;
   smir_parse_t f;

   smir_parser u_parser (
      .pclk(pclk),
      .presetn(presetn),
      .hdr_valid(hdr_valid && hdr_ready),
      .hdr_kind(hdr_kind),
      .hdr_flags(hdr_flags),
      .hdr_len(hdr_len),
      .byte_valid(byte_valid),
      .byte_data(byte_data),
      .done(done),
      .fields(f)
   );

   // a header is taken only while the parser is idle; its state already says so
   assign hdr_ready = (f.st == smir_idle);

   function automatic logic len_ok(input logic [7:0] kind, input logic [7:0] flags, input logic [15:0] len);
      logic ok;
      ok = 1'b1;
      if (kind == `SMIR_KIND_SRC_INFO)
         ok = (len >= `SMIR_LEN_SRC_INFO);
      else if (kind == `SMIR_KIND_TIME_INFO)
         ok = flags[`SMIR_FLAG_TS_ABSENT] || (len >= `SMIR_LEN_TIME_INFO);
      else if (kind == `SMIR_KIND_FRAG_NACK)
         ok = (len >= `SMIR_LEN_FRAG_NACK);
      return ok;
   endfunction

   function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] r);
      return a == r;
   endfunction

   always_comb begin
      logic valid;
      logic [`SMIR_IRQ_W-1:0] ev;
      logic wr, rd;
      d = q;
      ev = '0;
      valid = 1'b0;
      wr = psel && penable && pwrite;
      rd = psel && !penable && !pwrite;
      // the info context, except source version and vendor, lives only until the next message starts
      if (msg_start) begin
         d.source_prefix = `SMIR_ZERO_PREFIX;
         d.ucast_reply = `SMIR_NULL_LOCATOR;
         d.mcast_reply = `SMIR_NULL_LOCATOR;
         d.timestamp_valid = 1'b0;
      end
      if (done) begin
         valid = len_ok(f.kind, f.flags, f.len);
         case (f.kind)
            `SMIR_KIND_SRC_INFO: begin
               if (valid) begin
                  d.source_prefix = f.src_prefix;
                  d.src_ver = f.src_ver;
                  d.src_vendor = f.src_vendor;
                  d.ucast_reply = `SMIR_NULL_LOCATOR;
                  d.mcast_reply = `SMIR_NULL_LOCATOR;
                  d.timestamp_valid = 1'b0;
                  ev[`SMIR_IRQ_SRC] = 1'b1;
               end
            end
            `SMIR_KIND_TIME_INFO: begin
               if (valid) begin
                  if (!f.flags[`SMIR_FLAG_TS_ABSENT]) begin
                     d.timestamp_valid = 1'b1;
                     d.timestamp = q.skew_detected ? 64'(f.ts_raw + reception_time - send_timestamp)
                                                   : f.ts_raw;
                  end else begin
                     d.timestamp_valid = 1'b0;
                  end
                  ev[`SMIR_IRQ_TIME] = 1'b1;
               end
            end
            `SMIR_KIND_FRAG_NACK: begin
               // sequence number must be positive, set size bounded and base nonzero
               valid = valid && !f.nk_seq[63] && (f.nk_seq != 64'h0) && (f.nk_base != 32'h0)
                       && (f.nk_nbits <= `SMIR_NBITS_MAX);
               if (valid) begin
                  // only the nack record is loaded; context stays
                  d.wr_prefix = dest_prefix;
                  d.wr_entity = f.nk_writer;
                  d.rd_prefix = q.source_prefix;
                  d.rd_entity = f.nk_reader;
                  d.nk_seq = f.nk_seq;
                  // bits beyond nbits are undetermined, masked off here
                  d.nk_bitmap = (f.nk_nbits >= 32'h20) ? f.nk_bitmap
                                : (f.nk_bitmap & ~(32'hffffffff << f.nk_nbits[4:0]));
                  d.nk_base = f.nk_base;
                  d.nk_nbits = f.nk_nbits;
                  d.nk_count = f.nk_count;
                  ev[`SMIR_IRQ_NACK] = 1'b1;
               end
            end
            default: valid = 1'b1;
         endcase
         if (!valid)
            ev[`SMIR_IRQ_INVALID] = 1'b1;
      end
      d.nk_valid = done && valid && (f.kind == `SMIR_KIND_FRAG_NACK);
      // write one clears; a new event wins over the clear
      if (wr && reg_hit(paddr, `SMIR_ADDR_IRQ_STAT))
         d.irq_stat = q.irq_stat & ~pwdata[`SMIR_IRQ_W-1:0];
      d.irq_stat = d.irq_stat | ev;
      if (wr && reg_hit(paddr, `SMIR_ADDR_IRQ_MASK))
         d.irq_mask = pwdata[`SMIR_IRQ_W-1:0];
      if (wr && reg_hit(paddr, `SMIR_ADDR_CTRL))
         d.skew_detected = pwdata[0];
      if (rd) begin
         if (reg_hit(paddr, `SMIR_ADDR_STATUS))
            d.prdata = {31'h0, q.timestamp_valid};
         else if (reg_hit(paddr, `SMIR_ADDR_IRQ_STAT))
            d.prdata = 32'(q.irq_stat);
         else if (reg_hit(paddr, `SMIR_ADDR_IRQ_MASK))
            d.prdata = 32'(q.irq_mask);
         else if (reg_hit(paddr, `SMIR_ADDR_CTRL))
            d.prdata = {31'h0, q.skew_detected};
         else if (reg_hit(paddr, `SMIR_ADDR_TS_LO))
            d.prdata = q.timestamp[31:0];
         else if (reg_hit(paddr, `SMIR_ADDR_TS_HI))
            d.prdata = q.timestamp[63:32];
         else if (reg_hit(paddr, `SMIR_ADDR_PREFIX0))
            d.prdata = q.source_prefix[31:0];
         else if (reg_hit(paddr, `SMIR_ADDR_PREFIX1))
            d.prdata = q.source_prefix[63:32];
         else if (reg_hit(paddr, `SMIR_ADDR_PREFIX2))
            d.prdata = q.source_prefix[95:64];
         else if (reg_hit(paddr, `SMIR_ADDR_VER_VENDOR))
            d.prdata = {q.src_ver, q.src_vendor};
         else if (reg_hit(paddr, `SMIR_ADDR_NK_SEQ))
            d.prdata = q.nk_seq[31:0];
         else if (reg_hit(paddr, `SMIR_ADDR_NK_BITMAP))
            d.prdata = q.nk_bitmap;
         else if (reg_hit(paddr, `SMIR_ADDR_NK_BASE))
            d.prdata = q.nk_base;
         else if (reg_hit(paddr, `SMIR_ADDR_NK_COUNT))
            d.prdata = q.nk_count;
         else if (reg_hit(paddr, `SMIR_ADDR_NK_WRITER))
            d.prdata = q.wr_entity;
         else if (reg_hit(paddr, `SMIR_ADDR_NK_READER))
            d.prdata = q.rd_entity;
         else
            d.prdata = 32'h0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         q <= '0;
      else
         q <= d;
   end

   // unmapped addresses read zero and write nowhere; never an error
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign prdata = q.prdata;
   assign irq = |(q.irq_stat & q.irq_mask);
   assign data_ts_valid = q.timestamp_valid;
   assign data_ts = q.timestamp;
   assign ucast_reply = q.ucast_reply;
   assign mcast_reply = q.mcast_reply;
   assign nack_valid = q.nk_valid;
   assign nack_writer_guid = {q.wr_prefix, q.wr_entity};
   assign nack_reader_guid = {q.rd_prefix, q.rd_entity};
   assign nack_seq = q.nk_seq;
   assign nack_base = q.nk_base;
   assign nack_nbits = q.nk_nbits;
   assign nack_bitmap = q.nk_bitmap;
   assign nack_count = q.nk_count;
endmodule // smir_receiver

// File: tb/smir_receiver_asserts.sv
// smir_receiver_asserts: port-level checks of the submessage info receiver
// assumes it is bound to smir_receiver and sees only its ports
`timescale 1ns/1ns
module smir_receiver_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic msg_start,
   input wire logic [95:0] dest_prefix,
   input wire logic hdr_valid,
   input wire logic hdr_ready,
   input wire logic [15:0] hdr_len,
   input wire logic data_ts_valid,
   input wire logic [63:0] data_ts,
   input wire logic [7:0] ucast_reply,
   input wire logic [7:0] mcast_reply,
   input wire logic nack_valid,
   input wire logic [127:0] nack_writer_guid,
   input wire logic [63:0] nack_seq,
   input wire logic [31:0] nack_base,
   input wire logic [31:0] nack_nbits,
   input wire logic [31:0] nack_bitmap
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_nack_one_cycle: assert property (nack_valid |=> !nack_valid)
      else $error("nack pulse too long");
   a_nack_seq_pos: assert property (nack_valid |-> nack_seq != 64'h0 && !nack_seq[63])
      else $error("nack with bad sequence");
   a_nack_set_ok: assert property (nack_valid |-> nack_base != 32'h0 && nack_nbits <= 32'h100)
      else $error("nack with bad set");
   a_nack_writer_id: assert property (nack_valid |-> nack_writer_guid[127:32] == dest_prefix)
      else $error("writer prefix wrong");
   a_nack_undet_zero: assert property (nack_valid && nack_nbits < 32'h20 |-> (nack_bitmap >> nack_nbits) == 32'h0)
      else $error("bits past set size");
   a_msg_clears_ctx: assert property (msg_start |=> !data_ts_valid && ucast_reply == 8'h00 && mcast_reply == 8'h00)
      else $error("context kept past message");
   a_hdr_busy: assert property (hdr_valid && hdr_ready |=> !hdr_ready)
      else $error("header accepted while busy");
   a_ctx_holds_idle: assert property (hdr_ready && $past(hdr_ready) && !$past(msg_start)
      |-> $stable(data_ts_valid) && $stable(data_ts))
      else $error("timestamp changed while idle");
   c_nack: cover property (nack_valid);
   c_msg: cover property (msg_start);
   c_empty_hdr: cover property (hdr_valid && hdr_ready && hdr_len == 16'h0000);
endmodule // smir_receiver_asserts

bind smir_receiver smir_receiver_asserts u_asserts (.pclk(pclk), .presetn(presetn), .msg_start(msg_start),
   .dest_prefix(dest_prefix), .hdr_valid(hdr_valid), .hdr_ready(hdr_ready), .hdr_len(hdr_len),
   .data_ts_valid(data_ts_valid),
   .data_ts(data_ts), .ucast_reply(ucast_reply), .mcast_reply(mcast_reply), .nack_valid(nack_valid),
   .nack_writer_guid(nack_writer_guid), .nack_seq(nack_seq), .nack_base(nack_base), .nack_nbits(nack_nbits),
   .nack_bitmap(nack_bitmap));

// File: tb/smir_peer.sv
// smir_peer: remote endpoint model offering submessage headers and body bytes
// assumes the receiver takes a header on an edge with hdr_ready high
`timescale 1ns/1ns
module smir_peer (
   input wire logic pclk,
   input wire logic hdr_ready,
   output logic hdr_valid,
   output logic [7:0] hdr_kind,
   output logic [7:0] hdr_flags,
   output logic [15:0] hdr_len,
   output logic byte_valid,
   output logic [7:0] byte_data,
   output logic stuck
);
   initial begin
      hdr_valid = 1'h0;
      hdr_kind = 8'h00;
      hdr_flags = 8'h00;
      hdr_len = 16'h0000;
      byte_valid = 1'h0;
      byte_data = 8'h00;
      stuck = 1'h0;
   end
   // exactly n bytes in order; idle kind, length and data lines show inverted values so stale values never match
   task automatic send(input logic [7:0] k, input logic [7:0] f, input logic [15:0] n,
                       input logic [7:0] b [32], input int gap);
      int i;
      int w;
      @(posedge pclk);
      hdr_valid <= 1'h1;
      hdr_kind <= k;
      hdr_flags <= f;
      hdr_len <= n;
      w = 0;
      do begin
         @(posedge pclk);
         w++;
      end while (!hdr_ready && w < 50);
      if (!hdr_ready) stuck <= 1'h1;
      hdr_valid <= 1'h0;
      hdr_kind <= ~k;
      hdr_len <= ~n;
      for (i = 0; i < int'(n); i++) begin
         byte_valid <= 1'h1;
         byte_data <= b[i];
         @(posedge pclk);
         if (gap > 0 || i == int'(n) - 1) begin
            byte_valid <= 1'h0;
            byte_data <= ~b[i];
            repeat (gap) @(posedge pclk);
         end
      end
   endtask
endmodule // smir_peer

// File: tb/tb_smir_receiver.sv
// tb_smir_receiver: self-checking bench for the submessage info receiver
// assumes smir_peer drives the submessage stream; the bench is the apb master
`timescale 1ns/1ns
`include "smir_params.svh"
module tb_smir_receiver;
   typedef struct packed {
      logic le;
      logic [63:0] seq;
      logic [31:0] base;
      logic [31:0] nbits;
      logic [31:0] bmp;
      logic [31:0] exp_bmp;
      logic ok;
   } smir_row_t;
   smir_row_t rows [7] = '{
      '{1'h0, 64'h5, 32'h1, 32'h20, 32'hffffffff, 32'hffffffff, 1'h1},
      '{1'h1, 64'h0000000100000002, 32'h7, 32'h5, 32'hffffffff, 32'h0000001f, 1'h1},
      '{1'h0, 64'habc, 32'h2, 32'h100, 32'h12345678, 32'h12345678, 1'h1},
      '{1'h0, 64'h0, 32'h1, 32'h8, 32'hff, 32'h0, 1'h0},
      '{1'h1, 64'h8000000000000001, 32'h1, 32'h8, 32'hff, 32'h0, 1'h0},
      '{1'h0, 64'h9, 32'h0, 32'h8, 32'hff, 32'h0, 1'h0},
      '{1'h0, 64'h9, 32'h3, 32'h101, 32'hff, 32'h0, 1'h0}};
   logic pclk, presetn, msg_start, psel, penable, pwrite, pready, pslverr, irq;
   logic hdr_valid, hdr_ready, byte_valid, data_ts_valid, nack_valid, stuck, seen;
   logic [7:0] hdr_kind, hdr_flags, byte_data, ucast_reply, mcast_reply;
   logic [15:0] hdr_len;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, nack_base, nack_nbits, nack_bitmap, nack_count, cnt;
   logic [63:0] reception_time, send_timestamp, data_ts, nack_seq;
   logic [95:0] dest_prefix;
   logic [127:0] nack_writer_guid, nack_reader_guid;
   logic [7:0] body [32];
   int error_cnt, checked;
   smir_receiver dut (.pclk(pclk), .presetn(presetn), .msg_start(msg_start), .dest_prefix(dest_prefix),
      .reception_time(reception_time), .send_timestamp(send_timestamp), .hdr_valid(hdr_valid),
      .hdr_ready(hdr_ready), .hdr_kind(hdr_kind), .hdr_flags(hdr_flags), .hdr_len(hdr_len),
      .byte_valid(byte_valid), .byte_data(byte_data), .data_ts_valid(data_ts_valid), .data_ts(data_ts),
      .ucast_reply(ucast_reply), .mcast_reply(mcast_reply), .nack_valid(nack_valid),
      .nack_writer_guid(nack_writer_guid), .nack_reader_guid(nack_reader_guid), .nack_seq(nack_seq),
      .nack_base(nack_base), .nack_nbits(nack_nbits), .nack_bitmap(nack_bitmap), .nack_count(nack_count),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq));
   smir_peer peer (.pclk(pclk), .hdr_ready(hdr_ready), .hdr_valid(hdr_valid), .hdr_kind(hdr_kind),
      .hdr_flags(hdr_flags), .hdr_len(hdr_len), .byte_valid(byte_valid), .byte_data(byte_data), .stuck(stuck));
   initial begin
      pclk = 1'h0;
      forever #5 pclk = ~pclk;
   end
   task automatic chk(input logic [127:0] s, input logic [127:0] e);
      checked++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task give_verdict;
      if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int w;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      w = 0;
      do begin
         @(posedge pclk);
         w++;
      end while (!pready && w < 20);
      chk(pready, 1'h1);
      chk(pslverr, 1'h0);
      if (pready !== 1'h1) give_verdict();
      rd = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0);
      chk(rd, e);
   endtask
   function automatic void put(input int ofs, input int n, input logic [63:0] v, input logic le);
      for (int i = 0; i < n; i++) body[ofs + i] = le ? v[8 * i +: 8] : v[8 * (n - 1 - i) +: 8];
   endfunction
   // info submessage, then let the context update land
   task automatic info(input logic [7:0] k, input logic [7:0] f, input logic [15:0] n);
      peer.send(k, f, n, body, 0);
      repeat (3) @(posedge pclk);
   endtask
   initial begin
      presetn = 1'h0;
      msg_start = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      dest_prefix = 96'ha1a2a3a4a5a6a7a8a9aaabac;
      reception_time = 64'h500;
      send_timestamp = 64'h140;
      error_cnt = 0;
      checked = 0;
      cnt = 32'h0;
      body = '{default: 8'h00};
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      chk(hdr_ready, 1'h1);
      chk(irq, 1'h0);
      rd_chk(`SMIR_ADDR_STATUS, 32'h0);
      rd_chk(`SMIR_ADDR_IRQ_MASK, 32'h0);
      rd_chk(12'h100, 32'h0);
      put(0, 8, 64'h0102030405060708, 1'h0);
      info(`SMIR_KIND_TIME_INFO, 8'h00, 16'h0008);
      chk(data_ts_valid, 1'h1);
      chk(data_ts, 64'h0102030405060708);
      rd_chk(`SMIR_ADDR_TS_LO, 32'h05060708);
      put(4, 4, 64'h02050f0e, 1'h0);
      for (int i = 8; i < 20; i += 4) put(i, 4, 64'h5a5b5c5d, 1'h0);
      info(`SMIR_KIND_SRC_INFO, 8'h00, 16'h0014);
      chk(data_ts_valid, 1'h0);
      chk({ucast_reply, mcast_reply}, 16'h0000);
      rd_chk(`SMIR_ADDR_VER_VENDOR, 32'h02050f0e);
      rd_chk(`SMIR_ADDR_PREFIX1, 32'h5a5b5c5d);
      apb(1'h1, `SMIR_ADDR_IRQ_STAT, 32'hf);
      apb(1'h1, `SMIR_ADDR_IRQ_MASK, 32'h8);
      put(8, 4, 64'h0, 1'h0);
      info(`SMIR_KIND_SRC_INFO, 8'h00, 16'h0013);
      chk(irq, 1'h1);
      rd_chk(`SMIR_ADDR_IRQ_STAT, 32'h8);
      rd_chk(`SMIR_ADDR_PREFIX0, 32'h5a5b5c5d);
      apb(1'h1, `SMIR_ADDR_IRQ_STAT, 32'h8);
      @(posedge pclk);
      chk(irq, 1'h0);
      apb(1'h1, `SMIR_ADDR_CTRL, 32'h1);
      put(0, 8, 64'h1000, 1'h1);
      info(`SMIR_KIND_TIME_INFO, 8'h01, 16'h0008);
      chk(data_ts, 64'h13c0);
      apb(1'h1, `SMIR_ADDR_CTRL, 32'h0);
      peer.send(`SMIR_KIND_PAD, 8'h00, 16'h0005, body, 2);
      repeat (3) @(posedge pclk);
      chk({data_ts_valid, data_ts}, {1'h1, 64'h13c0});
      info(`SMIR_KIND_TIME_INFO, 8'h02, 16'h0000);
      chk(data_ts_valid, 1'h0);
      info(`SMIR_KIND_TIME_INFO, 8'h00, 16'h0004);
      chk(data_ts_valid, 1'h0);
      foreach (rows[r]) begin
         cnt++;
         put(0, 4, 64'h11223344, 1'h0);
         put(4, 4, 64'h00000102, 1'h0);
         put(8, 8, rows[r].seq, rows[r].le);
         put(16, 4, {32'h0, rows[r].base}, rows[r].le);
         put(20, 4, {32'h0, rows[r].nbits}, rows[r].le);
         put(24, 4, {32'h0, rows[r].bmp}, rows[r].le);
         put(28, 4, {32'h0, cnt}, rows[r].le);
         peer.send(`SMIR_KIND_FRAG_NACK, {7'h0, rows[r].le}, 16'h0020, body, 0);
         seen = 1'h0;
         for (int w = 0; w < 10 && !seen; w++) begin
            @(posedge pclk);
            seen = nack_valid;
         end
         chk(seen, rows[r].ok);
         if (rows[r].ok) begin
            chk(nack_seq, rows[r].seq);
            chk({nack_base, nack_nbits, nack_bitmap}, {rows[r].base, rows[r].nbits, rows[r].exp_bmp});
            chk(nack_count, cnt);
            chk(nack_writer_guid, {dest_prefix, 32'h00000102});
            chk(nack_reader_guid, {{3{32'h5a5b5c5d}}, 32'h11223344});
         end
      end
      rd_chk(`SMIR_ADDR_VER_VENDOR, 32'h02050f0e);
      put(0, 8, 64'h77, 1'h0);
      info(`SMIR_KIND_TIME_INFO, 8'h00, 16'h0008);
      @(posedge pclk);
      msg_start <= 1'h1;
      @(posedge pclk);
      msg_start <= 1'h0;
      repeat (2) @(posedge pclk);
      chk(data_ts_valid, 1'h0);
      rd_chk(`SMIR_ADDR_PREFIX2, 32'h0);
      chk(stuck, 1'h0);
      give_verdict();
   end
endmodule // tb_smir_receiver
